// File: hw/srr_pkg.sv
// Constants for the sensor result and event register bank
// Function
// - Event status holds command-done in bit 5, proximity flags in bits 4..2, light field in 1:0.
// - The alert pin is high while any status flag is set together with its enable bit.
// - With clear policy 0 a flag stays set until the host writes a one to its bit.
// - With clear policy 1 the sequencer clears all flags except proximity channels in mode 11.
// - The visible light result has its low byte at 0x22 and its high byte at 0x23.
// - The infrared light result has its low byte at 0x24 and its high byte at 0x25.
// - The first proximity result has its low byte at 0x26 and its high byte at 0x27.
// - The second proximity result has its low byte at 0x28.
// - All result bytes and the event status register reset to zero.
// - The second proximity result has its high byte at 0x29.
package srr_pkg;

    // Register offsets
    localparam logic [7:0] SRR_EVT_STATUS_OFS = 8'h21;
    localparam logic [7:0] SRR_VIS_LOW_OFS    = 8'h22;
    localparam logic [7:0] SRR_VIS_HIGH_OFS   = 8'h23;
    localparam logic [7:0] SRR_IR_LOW_OFS     = 8'h24;
    localparam logic [7:0] SRR_IR_HIGH_OFS    = 8'h25;
    localparam logic [7:0] SRR_PROX1_LOW_OFS  = 8'h26;
    localparam logic [7:0] SRR_PROX1_HIGH_OFS = 8'h27;
    localparam logic [7:0] SRR_PROX2_LOW_OFS  = 8'h28;
    localparam logic [7:0] SRR_PROX2_HIGH_OFS = 8'h29;

    // Result channel order in the result array
    localparam int SRR_CH_VIS   = 0;
    localparam int SRR_CH_IR    = 1;
    localparam int SRR_CH_PROX1 = 2;
    localparam int SRR_CH_PROX2 = 3;
    localparam int SRR_NUM_RES  = 4;

    // Event status field layout
    localparam int SRR_CMD_BIT       = 5;
    localparam int SRR_PROX3_BIT     = 4;
    localparam int SRR_PROX2_BIT     = 3;
    localparam int SRR_PROX1_BIT     = 2;
    localparam int SRR_LIGHT_MSB     = 1;
    localparam int SRR_LIGHT_LSB     = 0;
    localparam int SRR_NUM_PROX      = 3;
    localparam int SRR_EVT_BITS      = 6;

    // Writable status bits; bits 7:6 reserved
    localparam logic [7:0] SRR_EVT_MASK = 8'h3F;

    // Proximity alert mode that survives automatic clearing
    localparam logic [1:0] SRR_PROX_MODE_KEEP = 2'h3;

    // Reset values
    localparam logic [7:0]  SRR_EVT_RESET = 8'h00;
    localparam logic [15:0] SRR_RES_RESET = 16'h0000;
    localparam logic [7:0]  SRR_RD_IDLE   = 8'h00;

endpackage

// File: hw/srr_regs.sv
// Event status and measurement result register bank
`timescale 1ns/10ps

module srr_regs
    import srr_pkg::*;
#(
    parameter int RES_W = 16
) (
    // Clock and reset
    input  wire logic                          clock_i,
    input  wire logic                          sys_rst_i,
    // Internal register port behind the serial interface
    input  wire logic [7:0]                    reg_addr_i,
    input  wire logic                          reg_wr_i,
    input  wire logic [7:0]                    reg_wdata_i,
    input  wire logic                          reg_rd_i,
    output logic      [7:0]                    reg_rdata_o,
    output logic                               reg_rvalid_o,
    // Sequencer events and results
    input  wire logic [SRR_EVT_BITS-1:0]       evt_set_i,
    input  wire logic                          seq_autoclr_i,
    input  wire logic [SRR_NUM_RES-1:0]        res_load_i,
    input  wire logic [SRR_NUM_RES-1:0][15:0]  res_data_i,
    // Configuration held outside this bank
    input  wire logic                          clear_policy_i,
    input  wire logic [SRR_NUM_PROX-1:0][1:0]  prox_alert_mode_i,
    input  wire logic [7:0]                    evt_enable_i,
    // Host alert pin
    output logic                               alert_o,
    // Status view
    output logic      [7:0]                    evt_status_o
);

    initial begin
        if (RES_W != 16) begin
            $error("srr_regs: results are two bytes wide");
        end
    end

    logic [7:0]  evt_q;
    logic [7:0]  evt_d;
    logic        alert_q;
    logic        alert_d;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;
    logic        rvalid_q;
    logic        rvalid_d;
    logic [SRR_NUM_RES-1:0][15:0] res_q;
    logic [SRR_NUM_RES-1:0][15:0] res_d;
    logic        wr_evt;
    logic [7:0]  keep_mask;
    logic [7:0]  set_vec;

    assign wr_evt  = reg_wr_i && (reg_addr_i == SRR_EVT_STATUS_OFS);
    assign set_vec = {2'b00, evt_set_i} & SRR_EVT_MASK;

    // Channels in mode 11 keep their flag through automatic clearing
    always_comb begin
        keep_mask = SRR_EVT_RESET;
        keep_mask[SRR_PROX1_BIT] = (prox_alert_mode_i[0] == SRR_PROX_MODE_KEEP);
        keep_mask[SRR_PROX2_BIT] = (prox_alert_mode_i[1] == SRR_PROX_MODE_KEEP);
        keep_mask[SRR_PROX3_BIT] = (prox_alert_mode_i[2] == SRR_PROX_MODE_KEEP);
    end

    // Event status: clears first, then sets, so a new event is never lost
    always_comb begin
        evt_d = evt_q;
        if (!clear_policy_i && wr_evt) begin
            evt_d = evt_d & ~(reg_wdata_i & SRR_EVT_MASK);
        end
        if (clear_policy_i && seq_autoclr_i) begin
            evt_d = evt_d & keep_mask;
        end
        evt_d = (evt_d | set_vec) & SRR_EVT_MASK;
    end

    // Alert follows pending enabled events
    always_comb begin
        alert_d = |(evt_d & evt_enable_i & SRR_EVT_MASK);
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            evt_q   <= SRR_EVT_RESET;
            alert_q <= 1'b0;
        end else begin
            evt_q   <= evt_d;
            alert_q <= alert_d;
        end
    end

    // Result words; a sequencer load overwrites unread data and beats a host write
    genvar ch;
    generate
        for (ch = 0; ch < SRR_NUM_RES; ch++) begin : g_res
            logic [7:0] lo_ofs;
            logic [7:0] hi_ofs;
            assign lo_ofs = SRR_VIS_LOW_OFS + 8'(2 * ch);
            assign hi_ofs = SRR_VIS_HIGH_OFS + 8'(2 * ch);

            always_comb begin
                res_d[ch] = res_q[ch];
                if (res_load_i[ch]) begin
                    res_d[ch] = res_data_i[ch];
                end else if (reg_wr_i && (reg_addr_i == lo_ofs)) begin
                    res_d[ch][7:0] = reg_wdata_i;
                end else if (reg_wr_i && (reg_addr_i == hi_ofs)) begin
                    res_d[ch][15:8] = reg_wdata_i;
                end
            end

            always_ff @(posedge clock_i) begin
                if (sys_rst_i) begin
                    res_q[ch] <= SRR_RES_RESET;
                end else begin
                    res_q[ch] <= res_d[ch];
                end
            end
        end
    endgenerate

    // Read path, one cycle latency; unmapped offsets read zero
    always_comb begin
        rvalid_d = reg_rd_i;
        rdata_d  = rdata_q;
        if (reg_rd_i) begin
            if (reg_addr_i == SRR_EVT_STATUS_OFS) begin
                rdata_d = evt_q & SRR_EVT_MASK;
            end else if (reg_addr_i == SRR_VIS_LOW_OFS) begin
                rdata_d = res_q[SRR_CH_VIS][7:0];
            end else if (reg_addr_i == SRR_VIS_HIGH_OFS) begin
                rdata_d = res_q[SRR_CH_VIS][15:8];
            end else if (reg_addr_i == SRR_IR_LOW_OFS) begin
                rdata_d = res_q[SRR_CH_IR][7:0];
            end else if (reg_addr_i == SRR_IR_HIGH_OFS) begin
                rdata_d = res_q[SRR_CH_IR][15:8];
            end else if (reg_addr_i == SRR_PROX1_LOW_OFS) begin
                rdata_d = res_q[SRR_CH_PROX1][7:0];
            end else if (reg_addr_i == SRR_PROX1_HIGH_OFS) begin
                rdata_d = res_q[SRR_CH_PROX1][15:8];
            end else if (reg_addr_i == SRR_PROX2_LOW_OFS) begin
                rdata_d = res_q[SRR_CH_PROX2][7:0];
            end else if (reg_addr_i == SRR_PROX2_HIGH_OFS) begin
                rdata_d = res_q[SRR_CH_PROX2][15:8];
            end else begin
                rdata_d = SRR_RD_IDLE;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rdata_q  <= SRR_RD_IDLE;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata_o  = rdata_q;
    assign reg_rvalid_o = rvalid_q;
    assign alert_o      = alert_q;
    assign evt_status_o = evt_q;

endmodule

// File: dv/srr_regs_props.sv
// Checker for the result and event register bank
`timescale 1ns/10ps
module srr_regs_props
    import srr_pkg::*;
(
    // Watched ports
    input wire logic clock_i, sys_rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o,
    input wire logic seq_autoclr_i, clear_policy_i, alert_o,
    input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, evt_enable_i, evt_status_o,
    input wire logic [SRR_EVT_BITS-1:0] evt_set_i,
    input wire logic [SRR_NUM_PROX-1:0][1:0] prox_alert_mode_i
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    logic st_wr;
    assign st_wr = reg_wr_i && reg_addr_i == SRR_EVT_STATUS_OFS;
    sequence s_lone_rd; reg_rd_i ##1 !reg_rd_i; endsequence
    sequence s_rv_pulse; reg_rvalid_o ##1 !reg_rvalid_o; endsequence
    a_read_answer: assert property (s_lone_rd |-> s_rv_pulse)
        else $error("read answer not one pulse");
    a_rdata_hold: assert property (!reg_rd_i |=> !reg_rvalid_o && $stable(reg_rdata_o))
        else $error("read data moved without read");
    a_alert_map: assert property ($stable(evt_enable_i) |->
        alert_o == |(evt_status_o & evt_enable_i)) else $error("alert mismatch");
    a_set_flag: assert property (|evt_set_i |=>
        (evt_status_o[5:0] & $past(evt_set_i)) == $past(evt_set_i)) else $error("flag not set");
    a_w1c_clear: assert property (st_wr && !clear_policy_i && !evt_set_i |=>
        (evt_status_o[5:0] & $past(reg_wdata_i[5:0])) == 0) else $error("flag not cleared");
    a_flag_hold: assert property (!clear_policy_i && !st_wr |=>
        (evt_status_o & $past(evt_status_o)) == $past(evt_status_o)) else $error("flag lost");
    a_auto_clear: assert property (clear_policy_i && seq_autoclr_i && !evt_set_i |=>
        !evt_status_o[5] && evt_status_o[1:0] == 0) else $error("autoclear missed");
    a_auto_keep: assert property (clear_policy_i && seq_autoclr_i && evt_status_o[2]
        && prox_alert_mode_i[0] == SRR_PROX_MODE_KEEP |=> evt_status_o[2])
        else $error("kept flag lost");
endmodule

// File: dv/srr_host.sv
// Host model driving the register port
`timescale 1ns/10ps
module srr_host (
    input  wire logic       clock_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o
);
    initial {addr_o, wdata_o, wr_o, rd_o} = '0;
    // Released fields show inverted values so stale data is not mistaken
    task automatic wr(input logic [7:0] a, dat);
        @(posedge clock_i); #1;
        {addr_o, wdata_o, wr_o} = {a, dat, 1'b1};
        @(posedge clock_i); #1;
        {addr_o, wdata_o, wr_o} = {~a, ~dat, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] dat);
        @(posedge clock_i); #1;
        {addr_o, rd_o} = {a, 1'b1};
        @(posedge clock_i); #1;
        {addr_o, rd_o} = {~a, 1'b0};
        dat = rvalid_i ? rdata_i : 8'hxx;
    endtask
endmodule

// File: dv/srr_regs_tb.sv
// Self-checking bench for the result and event register bank
`timescale 1ns/10ps
module srr_regs_tb
    import srr_pkg::*;
;
    logic clock_i = 0, sys_rst_i = 1, reg_wr_i, reg_rd_i, reg_rvalid_o, alert_o;
    logic seq_autoclr_i = 0, clear_policy_i = 0;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, evt_status_o, evt_enable_i = 0, d, v;
    logic [SRR_EVT_BITS-1:0] evt_set_i = 0;
    logic [SRR_NUM_RES-1:0] res_load_i = 0;
    logic [SRR_NUM_RES-1:0][15:0] res_data_i = '0;
    logic [SRR_NUM_PROX-1:0][1:0] prox_alert_mode_i = '0;
    int num_errors = 0, compares = 0, st_m = 0, res_m[4];
    always #10 clock_i = ~clock_i;
    srr_regs dut (.*);
    srr_host hst (.clock_i, .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o),
        .addr_o(reg_addr_i), .wdata_o(reg_wdata_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i));
    task automatic chk(input logic [7:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic seq(input logic [5:0] ev, input logic [3:0] ld, input logic ac);
        @(posedge clock_i); #1;
        {evt_set_i, res_load_i, seq_autoclr_i} = {ev, ld, ac};
        @(posedge clock_i); #1;
        {evt_set_i, res_load_i, seq_autoclr_i} = '0;
    endtask
    task automatic rdc(input int a, e);
        hst.rd(8'(a), d);
        chk(d, 8'(e));
    endtask
    initial begin
        #100us;
        num_errors++;
        finish_test;
    end
    initial begin
        void'($urandom(12));
        repeat (2) @(posedge clock_i);
        #1 sys_rst_i = 0;
        for (int a = 'h21; a <= 'h2A; a++) rdc(a, 0);
        $display("reset test done");
        for (int c = 0; c < 4; c++) begin
            res_data_i[c] = 16'($urandom);
            res_m[c] = res_data_i[c];
            seq(0, 4'(1 << c), 0);
        end
        hst.wr(SRR_IR_HIGH_OFS, 8'h5A);
        res_m[1] = res_m[1] & 'hFF | 'h5A00;
        for (int a = 'h22; a <= 'h29; a++) rdc(a, res_m[(a - 'h22) / 2] >> a % 2 * 8);
        $display("result test done");
        evt_enable_i = 8'h3F;
        repeat (4) begin
            v = 8'($urandom) & 8'h3F;
            seq(6'(v), 0, 0);
            st_m |= v;
            rdc(SRR_EVT_STATUS_OFS, st_m);
            chk(8'(alert_o), 8'(st_m != 0));
            v = 8'($urandom);
            hst.wr(SRR_EVT_STATUS_OFS, v);
            st_m &= ~v & 'h3F;
            rdc(SRR_EVT_STATUS_OFS, st_m);
            chk(evt_status_o, 8'(st_m));
            chk(8'(alert_o), 8'(st_m != 0));
        end
        // Prox1 keeps its flag, the others may not use the keep mode
        clear_policy_i = 1;
        prox_alert_mode_i = {2'($urandom % 3), 2'b01, 2'b11};
        seq(6'h3F, 0, 0);
        hst.wr(SRR_EVT_STATUS_OFS, 8'hFF);
        rdc(SRR_EVT_STATUS_OFS, 'h3F);
        seq(0, 0, 1);
        evt_enable_i = 8'h3B;
        rdc(SRR_EVT_STATUS_OFS, 'h04);
        chk(8'(alert_o), 8'h00);
        chk(evt_status_o, 8'h04);
        $display("event test done");
        // Second reset in mid-run with a flag and results still held
        @(posedge clock_i);
        #1 sys_rst_i = 1;
        repeat (2) @(posedge clock_i);
        #1 sys_rst_i = 0;
        chk(evt_status_o, 8'h00);
        chk(8'(alert_o), 8'h00);
        for (int a = 'h21; a <= 'h29; a++) rdc(a, 0);
        $display("second reset test done");
        finish_test;
    end
endmodule
bind srr_regs srr_regs_props chk (.*);
